// ### logic/pattern_match_source_select.sv
// apb register block: slice source selection, slice configuration and
// pattern-match control storage, plus the edge-history clear output.
// assumes the slice detect logic sits outside and obeys HISTORY_CLEAR_O.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - each of the eight slices chooses its own input from eight inputs.
// - a choice code k routes pin interrupt input k to the slice.
// - any write to the source or configuration register clears history.
// - with interrupt select and event enable both zero, history is erased.
// - slice 0 choice lives in bits 10:8 and resets to zero.
// - slice 1 choice lives in bits 13:11 and resets to zero.
// - slice 2 choice lives in bits 16:14 and resets to zero.
// - slice 3 choice lives in bits 19:17 and resets to zero.
// - slice 4 choice lives in bits 22:20 and resets to zero.
// - slice 5 choice lives in bits 25:23 and resets to zero.
// - slice 6 choice lives in bits 28:26 and resets to zero.
// - slice 7 choice lives in bits 31:29 and resets to zero.
module pattern_match_source_select
  import pattern_match_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [DATA_W-1:0] PADDR_I,
  input wire logic [DATA_W-1:0] PWDATA_I,
  input wire logic [STRB_W-1:0] PSTRB_I,
  output logic [DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // pin interrupt inputs and live match state
  input wire logic [INPUT_COUNT-1:0] PIN_INT_I,
  input wire logic [MATCH_W-1:0] PRODUCT_MATCH_I,
  // towards the slice logic
  output logic [SLICE_COUNT-1:0] SLICE_INPUT_O,
  output logic HISTORY_CLEAR_O,
  output logic [DATA_W-1:0] SLICE_CONFIG_O,
  output logic PATTERN_INTERRUPT_SELECT_O,
  output logic EVENT_OUTPUT_ENABLE_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:CHOICE_BASE] src;
    logic [DATA_W-1:0] cfg;
    logic int_sel;
    logic event_en;
    logic [DATA_W-1:0] rdata;
    logic slverr;
    logic rd_valid;
    logic hist_clear;
    logic [SLICE_COUNT-1:0] slice_in;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [SLICE_COUNT-1:0] mux_out;
  logic hit_ctrl;
  logic hit_src;
  logic hit_cfg;
  logic hit_any;
  logic capture;
  logic done;
  logic wr_done;
  logic wr_clear;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] src_word;
  logic [DATA_W-1:0] src_merged;

  // ****************************************************************
  // byte-lane merge
  // ****************************************************************
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_val[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction : merge_bytes

  // ****************************************************************
  // source selection
  // ****************************************************************
  slice_source_mux #(
    .SLICES(SLICE_COUNT),
    .INPUTS(INPUT_COUNT),
    .SEL_W(CHOICE_W)
  ) u_mux (
    .pin_int_i(PIN_INT_I),
    .choice_i(s_reg.src),
    .slice_o(mux_out)
  );

  // ****************************************************************
  // address decode and read path
  // ****************************************************************
  assign hit_ctrl = (PADDR_I == CTRL_ADDR);
  assign hit_src = (PADDR_I == SRC_ADDR);
  assign hit_cfg = (PADDR_I == CFG_ADDR);
  assign hit_any = hit_ctrl | hit_src | hit_cfg;

  // read data is taken ahead of the access phase so it comes from flops
  assign capture = PSEL_I & ~s_reg.rd_valid;
  assign PREADY_O = CE_I & s_reg.rd_valid;
  assign done = PSEL_I & PENABLE_I & PREADY_O;
  assign wr_done = done & PWRITE_I & hit_any;
  // the written value is irrelevant: any source or configuration write wipes the history
  assign wr_clear = wr_done & (hit_src | hit_cfg);

  // reserved low byte is not stored and reads back as zero
  assign src_word = {s_reg.src, DATA_ZERO[CHOICE_BASE-1:0]};

  // merge into the full word first: a call result takes no part-select
  assign src_merged = merge_bytes(src_word, PWDATA_I, PSTRB_I);

  always_comb begin
    read_mux = DATA_ZERO;
    if (hit_src) begin
      read_mux = src_word;
    end else if (hit_cfg) begin
      read_mux = s_reg.cfg;
    end else if (hit_ctrl) begin
      read_mux[CTRL_INT_SEL_BIT] = s_reg.int_sel;
      read_mux[CTRL_EVENT_EN_BIT] = s_reg.event_en;
      read_mux[CTRL_MATCH_LO +: MATCH_W] = PRODUCT_MATCH_I;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    if (CE_I) begin
      if (capture) begin
        s_next.rdata = PWRITE_I ? DATA_ZERO : read_mux;
        s_next.slverr = ~hit_any;
        s_next.rd_valid = 1'b1;
      end
      if (done) begin
        s_next.rd_valid = 1'b0;
      end
      if (wr_done && hit_src) begin
        // fields at 10:8 up to 31:29, one per slice
        s_next.src = src_merged[DATA_W-1:CHOICE_BASE];
      end
      if (wr_done && hit_cfg) begin
        s_next.cfg = merge_bytes(s_reg.cfg, PWDATA_I, PSTRB_I);
      end
      if (wr_done && hit_ctrl && PSTRB_I[0]) begin
        s_next.int_sel = PWDATA_I[CTRL_INT_SEL_BIT];
        s_next.event_en = PWDATA_I[CTRL_EVENT_EN_BIT];
      end
      // feature off keeps the clear asserted as a level
      s_next.hist_clear = wr_clear |
                          ~(s_next.int_sel | s_next.event_en);
      s_next.slice_in = mux_out;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_reg.src <= SRC_RESET[DATA_W-1:CHOICE_BASE];
      s_reg.cfg <= CFG_RESET;
      s_reg.int_sel <= CTRL_BIT_RESET;
      s_reg.event_en <= CTRL_BIT_RESET;
      s_reg.rdata <= DATA_ZERO;
      s_reg.slverr <= 1'b0;
      s_reg.rd_valid <= 1'b0;
      s_reg.hist_clear <= 1'b1;
      s_reg.slice_in <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA_O = s_reg.rdata;
  assign PSLVERR_O = s_reg.slverr;
  assign SLICE_INPUT_O = s_reg.slice_in;
  assign HISTORY_CLEAR_O = s_reg.hist_clear;
  assign SLICE_CONFIG_O = s_reg.cfg;
  assign PATTERN_INTERRUPT_SELECT_O = s_reg.int_sel;
  assign EVENT_OUTPUT_ENABLE_O = s_reg.event_en;

  // ****************************************************************
  // checks
  // ****************************************************************
  // helper copies of the previous inputs, read only by the checks
  logic [INPUT_COUNT-1:0] pin_prev;
  logic [DATA_W-1:0] src_prev;
  always_ff @(posedge CLK_I) begin
    pin_prev <= PIN_INT_I;
    src_prev <= src_word;
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  property p_field(lo);
    (wr_done && hit_src && PSTRB_I == STRB_ALL)
      |=> (src_word[lo +: CHOICE_W] == $past(PWDATA_I[lo +: CHOICE_W]));
  endproperty

  a_slice0: assert property (p_field(8))
    else $error("slice 0 field not stored");
  a_slice1: assert property (p_field(11))
    else $error("slice 1 field not stored");
  a_slice2: assert property (p_field(14))
    else $error("slice 2 field not stored");
  a_slice3: assert property (p_field(17))
    else $error("slice 3 field not stored");
  a_slice4: assert property (p_field(20))
    else $error("slice 4 field not stored");
  a_slice5: assert property (p_field(23))
    else $error("slice 5 field not stored");
  a_slice6: assert property (p_field(26))
    else $error("slice 6 field not stored");
  a_slice7: assert property (p_field(29))
    else $error("slice 7 field not stored");

  property p_route(s);
    CE_I |=> (SLICE_INPUT_O[s] ==
              pin_prev[src_prev[CHOICE_BASE + s*CHOICE_W +: CHOICE_W]]);
  endproperty

  a_route0: assert property (p_route(0))
    else $error("slice 0 routed to wrong input");
  a_route1: assert property (p_route(1))
    else $error("slice 1 routed to wrong input");
  a_route7: assert property (p_route(7))
    else $error("slice 7 routed to wrong input");

  property p_wr_clear;
    (CE_I && done && PWRITE_I && (hit_src || hit_cfg))
      |=> HISTORY_CLEAR_O;
  endproperty
  a_wr_clear: assert property (p_wr_clear)
    else $error("write did not clear history");

  property p_dis_clear;
    (CE_I && !wr_done && !PATTERN_INTERRUPT_SELECT_O &&
     !EVENT_OUTPUT_ENABLE_O) |=> HISTORY_CLEAR_O;
  endproperty
  a_dis_clear: assert property (p_dis_clear)
    else $error("disabled feature kept history");

  property p_en_noclear;
    (CE_I && !wr_done && (PATTERN_INTERRUPT_SELECT_O ||
     EVENT_OUTPUT_ENABLE_O)) |=> !HISTORY_CLEAR_O;
  endproperty
  a_en_noclear: assert property (p_en_noclear)
    else $error("history cleared while enabled");

  // ****************************************************************
  // bus and enable checks
  // ****************************************************************
  // a low enable must hold the slice, clear, configuration and read-data outputs, or slice history would drift
  property p_freeze;
    !CE_I |=> ($stable(SLICE_INPUT_O) && $stable(HISTORY_CLEAR_O) &&
               $stable(SLICE_CONFIG_O) && $stable(PRDATA_O));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable low");

  property p_ready_wait;
    (CE_I && PSEL_I && !PENABLE_I && !PREADY_O) |=> (PREADY_O || !CE_I);
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("ready late after setup");

  property p_ready_drop;
    done |=> !PREADY_O;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready held after completion");

  property p_low_byte;
    (CE_I && capture && hit_src && !PWRITE_I)
      |=> (PRDATA_O[CHOICE_BASE-1:0] == DATA_ZERO[CHOICE_BASE-1:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("reserved source byte read nonzero");

  property p_unmapped_rd;
    (CE_I && capture && !hit_any) |=> (PSLVERR_O && PRDATA_O == DATA_ZERO);
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped access not refused");

  property p_unmapped_wr;
    (done && PWRITE_I && !hit_any)
      |=> ($stable(src_word) && $stable(SLICE_CONFIG_O));
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr)
    else $error("unmapped write changed a register");

  property p_cfg_store;
    (wr_done && hit_cfg && PSTRB_I == STRB_ALL)
      |=> (SLICE_CONFIG_O == $past(PWDATA_I));
  endproperty
  a_cfg_store: assert property (p_cfg_store)
    else $error("configuration word not stored");

  property p_ctrl_store;
    (wr_done && hit_ctrl && PSTRB_I[0])
      |=> (PATTERN_INTERRUPT_SELECT_O == $past(PWDATA_I[CTRL_INT_SEL_BIT]) &&
           EVENT_OUTPUT_ENABLE_O == $past(PWDATA_I[CTRL_EVENT_EN_BIT]));
  endproperty
  a_ctrl_store: assert property (p_ctrl_store)
    else $error("control bits not stored");

  // only lane 0 carries control bits; other lanes must not disturb them
  property p_ctrl_lane;
    (wr_done && hit_ctrl && !PSTRB_I[0])
      |=> ($stable(PATTERN_INTERRUPT_SELECT_O) &&
           $stable(EVENT_OUTPUT_ENABLE_O));
  endproperty
  a_ctrl_lane: assert property (p_ctrl_lane)
    else $error("control changed without lane 0");

  c_src_write: cover property (wr_done && hit_src ##1 HISTORY_CLEAR_O);
  c_cfg_write: cover property (wr_done && hit_cfg);
  c_bad_addr: cover property (done && PSLVERR_O);
  c_enable: cover property ($rose(PATTERN_INTERRUPT_SELECT_O));
  c_freeze: cover property (!CE_I ##1 CE_I);

endmodule : pattern_match_source_select

// ### logic/pattern_match_pkg.sv
// constants shared by the pattern-match source-select block and its mux
// assumes a 32-bit apb bus with byte addresses as printed
package pattern_match_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int SLICE_COUNT = 8;
  localparam int INPUT_COUNT = 8;
  localparam int CHOICE_W = 3;
  localparam int CHOICE_BASE = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int BYTE_W = 8;
  localparam int MATCH_W = 8;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] CTRL_ADDR = 32'hA000_4028;
  localparam logic [31:0] SRC_ADDR = 32'hA000_402C;
  localparam logic [31:0] CFG_ADDR = 32'hA000_4030;

  localparam logic [31:0] SRC_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic CTRL_BIT_RESET = 1'h0;

  // control register fields
  localparam int CTRL_INT_SEL_BIT = 0;
  localparam int CTRL_EVENT_EN_BIT = 1;
  localparam int CTRL_MATCH_LO = 24;

  localparam logic [3:0] STRB_ALL = 4'hF;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : pattern_match_pkg

// ### logic/slice_source_mux.sv
// per-slice input selector: each slice picks one pin interrupt input
// assumes choice codes never exceed the input count (power of two)
`timescale 1ns/1ps

module slice_source_mux #(
  parameter int SLICES = 8,
  parameter int INPUTS = 8,
  parameter int SEL_W = 3
) (
  // inputs
  input wire logic [INPUTS-1:0] pin_int_i,
  input wire logic [SLICES*SEL_W-1:0] choice_i,
  // selected inputs
  output logic [SLICES-1:0] slice_o
);

  // ****************************************************************
  // one selector per slice
  // ****************************************************************
  for (genvar g = 0; g < SLICES; g++) begin : g_slice
    // code k takes input k on every slice alike
    assign slice_o[g] = pin_int_i[choice_i[g*SEL_W +: SEL_W]];
  end

endmodule : slice_source_mux

// ### verif/pin_select_model.sv
// far-side model: pin select muxes feeding the eight pin interrupt inputs
// assumes the bench drives pad levels on the block clock
`timescale 1ns/1ps

module pin_select_model (
  input wire logic clk_i,
  input wire logic [7:0] pad_i,
  output logic [7:0] pin_int_o
);
  // input k is the pad routed by system select k; one sync stage
  always_ff @(posedge clk_i) begin
    pin_int_o <= pad_i;
  end
endmodule : pin_select_model

// ### verif/test_pattern_match_source_select.sv
// self-checking bench for the slice source-select register block
// assumes zero-wait apb answers are awaited, never counted
`timescale 1ns/1ps

module test_pattern_match_source_select;
  import pattern_match_pkg::*;
  logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, cfg, rd;
  logic [7:0] pads = 0, pmatch = 0, pins, slices;
  logic [3:0] pstrb = STRB_ALL;
  logic pready, pslverr, hclr, isel, evne, err;
  int n_errors = 0, n_tests = 0, cyc = 0;

  always #5 clk = ~clk;

  pin_select_model model (.clk_i(clk), .pad_i(pads), .pin_int_o(pins));
  pattern_match_source_select uut (.CLK_I(clk), .SYS_RST_I(rst),
    .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .PIN_INT_I(pins), .PRODUCT_MATCH_I(pmatch), .SLICE_INPUT_O(slices),
    .HISTORY_CLEAR_O(hclr), .SLICE_CONFIG_O(cfg),
    .PATTERN_INTERRUPT_SELECT_O(isel), .EVENT_OUTPUT_ENABLE_O(evne));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (exp !== got) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // returns in the completion edge's time step, so c2 can be observed;
  // ready and data are taken at that rising edge, never on a falling one
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge clk);
    check("clear after reset", 32'(hclr), 32'h1);
    check("slices after reset", 32'(slices), 32'h0);
    apb(1'b0, SRC_ADDR, DATA_ZERO);
    check("source reset", rd, SRC_RESET);
    check("read error", 32'(err), 32'h0);
    apb(1'b0, CFG_ADDR, DATA_ZERO);
    check("config reset", rd, CFG_RESET);
  endtask : t_reset

  task automatic t_route();
    logic [31:0] w;
    logic [7:0] exp;
    for (int k = 0; k < 8; k++) begin
      w = 32'h0;
      for (int s = 0; s < 8; s++) w[8 + 3 * s +: 3] = 3'((s + k) % 8);
      apb(1'b1, SRC_ADDR, w);
      apb(1'b0, SRC_ADDR, DATA_ZERO);
      check("source readback", rd, w);
      for (int j = 0; j < 8; j++) begin
        @(posedge clk);
        pads <= 8'h1 << j;
        repeat (3) @(posedge clk);
        @(negedge clk);
        for (int s = 0; s < 8; s++) exp[s] = (((s + k) % 8) == j);
        check("slice inputs", 32'(slices), 32'(exp));
      end
    end
  endtask : t_route

  task automatic t_clear();
    @(posedge clk);
    pmatch <= 8'h5A;
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    @(negedge clk);
    check("enabled clear", 32'(hclr), 32'h0);
    check("int select", 32'(isel), 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, i ? SRC_ADDR : CFG_ADDR, 32'h1234_5600);
      @(negedge clk);
      check("clear on write", 32'(hclr), 32'h1);
      @(negedge clk);
      check("clear ends", 32'(hclr), 32'h0);
    end
    check("config out", cfg, 32'h1234_5600);
    apb(1'b1, CTRL_ADDR, 32'h0000_0002);
    @(negedge clk);
    check("event only", 32'(hclr), 32'h0);
    check("event enable", 32'(evne), 32'h1);
    apb(1'b0, CTRL_ADDR, DATA_ZERO);
    check("control read", rd, 32'h5A00_0002);
    apb(1'b1, CTRL_ADDR, DATA_ZERO);
    repeat (2) @(negedge clk);
    check("disabled clear", 32'(hclr), 32'h1);
    @(posedge clk);
    pstrb <= 4'hE;
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    pstrb <= STRB_ALL;
    @(negedge clk);
    check("lane 0 off", 32'(isel), 32'h0);
    check("still clear", 32'(hclr), 32'h1);
  endtask : t_clear

  task automatic t_unmapped();
    apb(1'b1, 32'hA000_4034, 32'hFFFF_FFFF);
    check("unmapped error", 32'(err), 32'h1);
    apb(1'b0, 32'hA000_4034, DATA_ZERO);
    check("unmapped data", rd, 32'h0);
    apb(1'b0, SRC_ADDR, DATA_ZERO);
    check("source kept", rd, 32'h1234_5600);
  endtask : t_unmapped

  // enable low must freeze the slice path; it resumes once enable returns
  task automatic t_freeze();
    apb(1'b1, SRC_ADDR, DATA_ZERO);
    check("write error", 32'(err), 32'h0);
    pads <= 8'h00;
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    pads <= 8'hFF;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("frozen slices", 32'(slices), 32'h0);
    check("ready frozen", 32'(pready), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("slices resume", 32'(slices), 32'hFF);
  endtask : t_freeze

  // generous ceiling: the whole run needs about 380 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_clear();
    t_unmapped();
    t_freeze();
    give_verdict();
  end
endmodule : test_pattern_match_source_select
